//--- common/afe_pkg.sv
package afe_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_SETUP = 8'h00;
  localparam logic [7:0] OFF_INSEL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0C;
  // analog_setup_register fields
  localparam int BURN_LSB = 0;
  localparam int GAIN_LSB = 2;
  localparam int AZ_BIT = 5;
  localparam int KIND_LSB = 6;
  localparam int START_BIT = 8;
  localparam logic [8:0] SETUP_RST = 9'h004;
  localparam logic [7:0] INSEL_RST = 8'h01;
  // Temperature diode pair code and its nibbles
  localparam logic [7:0] TEMP_PAIR = 8'hDE;
  localparam logic [3:0] DIODE_P = 4'hD;
  localparam logic [3:0] DIODE_M = 4'hE;
  // Conversion kinds
  localparam logic [1:0] KIND_ONESHOT = 2'h2;
  localparam logic [1:0] KIND_CONT = 2'h3;
  // Gain codes; analog codes index 0.333,1,2,4,8,16
  localparam logic [2:0] GAIN_MAX_ANALOG = 3'h5;
  localparam logic [2:0] GAIN_X32 = 3'h6;
  localparam logic [2:0] GAIN_X64 = 3'h7;
  localparam logic [1:0] SHIFT_X1 = 2'h0;
  localparam logic [1:0] SHIFT_X2 = 2'h1;
  localparam logic [1:0] SHIFT_X4 = 2'h2;
  localparam logic [1:0] BURN_OFF = 2'h0;
  // Filter output carries two fraction bits below the 16-bit code
  localparam int RAW_W = 18;
  localparam int FRAC_W = 2;
  localparam int RES_W = 16;
  typedef enum logic {ST_IDLE, ST_CONV} conv_state_t;
endpackage

//--- verilog/digital_gain_shift.sv
`timescale 1ns/1ps
module digital_gain_shift
  import afe_pkg::*;
(
  input wire logic signed [afe_pkg::RAW_W-1:0] raw,
  input wire logic [1:0] shift,
  output logic signed [afe_pkg::RES_W-1:0] code
);
  localparam int EXT_W = RAW_W + 3;
  localparam logic signed [EXT_W-1:0] HALF_LSB = EXT_W'(1 <<< (FRAC_W - 1));
  localparam logic signed [EXT_W-1:0] MAX_CODE = EXT_W'(32767);
  localparam logic signed [EXT_W-1:0] MIN_CODE = -EXT_W'(32768);
  wire logic signed [EXT_W-1:0] ext = EXT_W'(raw);
  // Shift then round half up on the dropped fraction bits
  wire logic signed [EXT_W-1:0] shifted = ext <<< shift;
  wire logic signed [EXT_W-1:0] rounded = (shifted + HALF_LSB) >>> FRAC_W;
  // Saturate instead of wrapping when gain pushes past full scale
  assign code = (rounded > MAX_CODE) ? RES_W'(MAX_CODE) :
                (rounded < MIN_CODE) ? RES_W'(MIN_CODE) : rounded[RES_W-1:0];
endmodule // digital_gain_shift

//--- verilog/adc_front_end_control.sv
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Burnout select 00 is off; 01, 10, 11 pick 0.9, 3.7, 15 uA.
// - Pair select 0xDE routes P diode to positive, M diode to negative input.
// - Temperature diodes chosen: burnout off, diode bias on, select bits kept.
// - Offset-cancel bit 0 (reset) leaves conversions alone; 1 enables it.
// - Offset cancel: two conversions, second swapped, result is difference halved.
// - Offset cancel doubles conversion time per result; one-shot simply doubles.
// - Offset cancel in continuous: back-to-back one-shots with filter reset between.
// - Gain 000..101 gives analog 0.333,1,2,4,8,16 with digital gain 1.
// - Gain 110, 111 hold analog 16 and add digital gain 2 or 4.
// - Digital gain is a left shift by one or two bits with rounding.
module adc_front_end_control
  import afe_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scan_temp_active,
  input wire logic conv_done,
  input wire logic signed [afe_pkg::RAW_W-1:0] conv_raw,
  output logic conv_start,
  output logic filter_reset,
  output logic swap_inputs,
  output logic [3:0] vin_pos_sel,
  output logic [3:0] vin_neg_sel,
  output logic [1:0] burnout_sel,
  output logic diode_bias_en,
  output logic [2:0] analog_gain,
  output logic [1:0] digital_shift,
  output logic result_valid,
  output logic [15:0] result_word
);
  conv_state_t state_r;
  logic [8:0] setup_r;
  logic [7:0] insel_r;
  logic [2:0] gain_lat_r;
  logic az_lat_r;
  logic [1:0] burn_lat_r;
  logic phase_r;
  logic signed [RES_W-1:0] first_r;
  logic conv_start_r;
  logic filter_reset_r;
  logic swap_r;
  logic result_valid_r;
  logic [RES_W-1:0] result_r;

  // APB decode; zero wait states, unmapped offsets answer with an error
  wire logic acc = psel && penable;
  wire logic hit_setup = paddr == OFF_SETUP;
  wire logic hit_insel = paddr == OFF_INSEL;
  wire logic hit_status = paddr == OFF_STATUS;
  wire logic hit_result = paddr == OFF_RESULT;
  wire logic mapped = hit_setup || hit_insel || hit_status || hit_result;
  wire logic wr_setup = acc && pwrite && hit_setup;
  wire logic wr_insel = acc && pwrite && hit_insel;
  wire logic start_req = wr_setup && pwdata[START_BIT];
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // Settings written together with the start bit must be the ones latched
  wire logic [8:0] setup_cur = wr_setup ? {1'b0, pwdata[7:0]} : setup_r;
  wire logic [1:0] burn_cfg = setup_cur[BURN_LSB +: 2];
  wire logic [2:0] gain_cfg = setup_cur[GAIN_LSB +: 3];
  wire logic az_cfg = setup_cur[AZ_BIT];
  wire logic [1:0] kind_cfg = setup_cur[KIND_LSB +: 2];
  wire logic cont_mode = kind_cfg == KIND_CONT;

  // Diode selection acts at once, independent of any conversion
  wire logic temp_sel = (insel_r == TEMP_PAIR) || scan_temp_active;
  wire logic [31:0] status_word = {26'h0, swap_r, phase_r, az_lat_r, temp_sel,
                                   result_valid_r, state_r == ST_CONV};
  assign prdata = !acc || pwrite ? 32'h0 :
                  hit_setup ? {23'h0, 1'b0, setup_r[7:0]} :
                  hit_insel ? {24'h0, insel_r} :
                  hit_status ? status_word :
                  hit_result ? {16'h0, result_r} : 32'h0;

  // Gain split: analog saturates at 16x, the rest is a digital shift
  assign analog_gain = (gain_lat_r > GAIN_MAX_ANALOG) ? GAIN_MAX_ANALOG : gain_lat_r;
  assign digital_shift = (gain_lat_r == GAIN_X64) ? SHIFT_X4 :
                         (gain_lat_r == GAIN_X32) ? SHIFT_X2 : SHIFT_X1;

  // Stored select bits are untouched; only the driven code is forced off
  assign burnout_sel = temp_sel ? BURN_OFF : burn_lat_r;
  assign diode_bias_en = temp_sel;
  // Nibbles go straight through, so 0xDE lands P on positive and M on negative
  assign vin_pos_sel = swap_r ? insel_r[3:0] : insel_r[7:4];
  assign vin_neg_sel = swap_r ? insel_r[7:4] : insel_r[3:0];

  logic signed [RES_W-1:0] gained;
  digital_gain_shift i_digital_gain_shift (
    .raw(conv_raw),
    .shift(digital_shift),
    .code(gained)
  );

  wire logic signed [RES_W:0] diff = {first_r[RES_W-1], first_r} - {gained[RES_W-1], gained};
  wire logic [RES_W-1:0] half_diff = diff[RES_W:1];
  wire logic go_idle = start_req || cont_mode;
  wire logic in_conv = state_r == ST_CONV;
  wire logic need_second = in_conv && conv_done && az_lat_r && !phase_r;
  wire logic finish = in_conv && conv_done && !need_second;
  wire logic again = finish && cont_mode;
  // Settings are re-sampled whenever a fresh conversion starts
  wire logic relatch = (state_r == ST_IDLE && go_idle) || again;

  assign conv_start = conv_start_r;
  assign filter_reset = filter_reset_r;
  assign swap_inputs = swap_r;
  assign result_valid = result_valid_r;
  assign result_word = result_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      setup_r <= SETUP_RST;
      insel_r <= INSEL_RST;
    end else begin
      if (wr_setup) begin
        setup_r <= {1'b0, pwdata[7:0]};
      end
      if (wr_insel) begin
        insel_r <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      gain_lat_r <= SETUP_RST[GAIN_LSB +: 3];
      az_lat_r <= SETUP_RST[AZ_BIT];
      burn_lat_r <= BURN_OFF;
    end else if (relatch) begin
      gain_lat_r <= gain_cfg;
      az_lat_r <= az_cfg;
      burn_lat_r <= burn_cfg;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      phase_r <= 1'b0;
      swap_r <= 1'b0;
      conv_start_r <= 1'b0;
      filter_reset_r <= 1'b0;
    end else begin
      conv_start_r <= 1'b0;
      filter_reset_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (go_idle) begin
            state_r <= ST_CONV;
            conv_start_r <= 1'b1;
            filter_reset_r <= 1'b1;
            phase_r <= 1'b0;
            swap_r <= 1'b0;
          end
        end
        ST_CONV: begin
          if (need_second) begin
            // Second half with inputs swapped, filter restarted clean
            phase_r <= 1'b1;
            swap_r <= 1'b1;
            conv_start_r <= 1'b1;
            filter_reset_r <= 1'b1;
          end else if (finish) begin
            phase_r <= 1'b0;
            swap_r <= 1'b0;
            if (cont_mode) begin
              // Plain continuous keeps the filter running; offset cancel restarts it
              conv_start_r <= az_cfg;
              filter_reset_r <= az_cfg;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      first_r <= '0;
      result_r <= '0;
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= finish;
      if (need_second) begin
        first_r <= gained;
      end
      if (finish) begin
        result_r <= az_lat_r ? half_diff : gained;
      end
    end
  end

  property p_temp_burnout;
    @(posedge mclk) disable iff (srst)
      temp_sel |-> (burnout_sel == BURN_OFF) && diode_bias_en;
  endproperty
  a_temp_burnout: assert property (p_temp_burnout)
    else $error("burnout active while temperature diodes selected");

  property p_diode_route;
    @(posedge mclk) disable iff (srst)
      (insel_r == TEMP_PAIR && !swap_r) |-> vin_pos_sel == DIODE_P && vin_neg_sel == DIODE_M;
  endproperty
  a_diode_route: assert property (p_diode_route)
    else $error("diode pair not routed P to positive");

  property p_burn_sample;
    @(posedge mclk) disable iff (srst)
      (relatch && !temp_sel) ##1 !temp_sel |-> burnout_sel == $past(burn_cfg);
  endproperty
  a_burn_sample: assert property (p_burn_sample)
    else $error("burnout code not taken from setting at start");

  property p_gain_low;
    @(posedge mclk) disable iff (srst)
      relatch && gain_cfg <= GAIN_MAX_ANALOG |=> analog_gain == $past(gain_cfg)
        && digital_shift == SHIFT_X1;
  endproperty
  a_gain_low: assert property (p_gain_low)
    else $error("low gain code decoded wrongly");

  property p_gain_high;
    @(posedge mclk) disable iff (srst)
      relatch && gain_cfg > GAIN_MAX_ANALOG |=> analog_gain == GAIN_MAX_ANALOG
        && digital_shift == ((gain_cfg == GAIN_X64) ? SHIFT_X4 : SHIFT_X2);
  endproperty
  a_gain_high: assert property (p_gain_high)
    else $error("high gain code decoded wrongly");

  property p_az_second;
    @(posedge mclk) disable iff (srst)
      need_second |=> conv_start && filter_reset && swap_inputs && phase_r;
  endproperty
  a_az_second: assert property (p_az_second)
    else $error("second swapped conversion not launched");

  property p_az_result;
    @(posedge mclk) disable iff (srst)
      finish && az_lat_r |=> result_valid && result_word == $past(half_diff)
        && $past(phase_r) && !swap_inputs;
  endproperty
  a_az_result: assert property (p_az_result)
    else $error("offset-cancel result is not half the difference");

  property p_plain_result;
    @(posedge mclk) disable iff (srst)
      finish && !az_lat_r |=> result_valid && result_word == $past(gained)
        && !swap_inputs;
  endproperty
  a_plain_result: assert property (p_plain_result)
    else $error("plain conversion result altered");

  property p_cont_az_reset;
    @(posedge mclk) disable iff (srst)
      finish && cont_mode && az_cfg |=> filter_reset && conv_start && in_conv;
  endproperty
  a_cont_az_reset: assert property (p_cont_az_reset)
    else $error("continuous offset cancel lacks filter reset");

  property p_hold_settings;
    @(posedge mclk) disable iff (srst)
      in_conv && !conv_done |=> $stable(gain_lat_r) && $stable(az_lat_r)
        && $stable(burn_lat_r);
  endproperty
  a_hold_settings: assert property (p_hold_settings)
    else $error("settings changed mid conversion");

  property p_shift_round;
    @(posedge mclk) disable iff (srst)
      digital_shift == SHIFT_X2 && conv_raw == 18'sh00006 |-> gained == 16'sh0003;
  endproperty
  a_shift_round: assert property (p_shift_round)
    else $error("digital gain shift or rounding wrong");
endmodule // adc_front_end_control

//--- verification/adc_front_end_control_tb_top.sv
`timescale 1ns/1ps
module adc_front_end_control_tb_top;
  import afe_pkg::*;
  logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic scan_temp_active = 0, conv_done = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic signed [RAW_W-1:0] conv_raw = '0;
  logic [31:0] prdata;
  logic pready, pslverr, conv_start, filter_reset, swap_inputs, diode_bias_en, result_valid;
  logic [3:0] vin_pos_sel, vin_neg_sel;
  logic [1:0] burnout_sel, digital_shift;
  logic [2:0] analog_gain;
  logic [15:0] result_word;
  logic [15:0] lfsr = 16'h0047;
  logic [7:0] insel;
  logic fr_seen, sw_seen;
  logic [15:0] last_exp = 16'h0;
  logic [15:0] exp_q[$];
  int fail_count = 0, n_compared = 0, cyc = 0, n_start = 0, seen_starts = 0;

  adc_front_end_control i_adc_front_end_control(.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scan_temp_active(scan_temp_active),
    .conv_done(conv_done), .conv_raw(conv_raw), .conv_start(conv_start),
    .filter_reset(filter_reset), .swap_inputs(swap_inputs), .vin_pos_sel(vin_pos_sel),
    .vin_neg_sel(vin_neg_sel), .burnout_sel(burnout_sel), .diode_bias_en(diode_bias_en),
    .analog_gain(analog_gain), .digital_shift(digital_shift), .result_valid(result_valid),
    .result_word(result_word));

  always #2 mclk = ~mclk;

  task automatic complete_run();
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Round half up, then clamp to the 16-bit code range
  function automatic logic [15:0] gained(input logic signed [17:0] raw, input int sh);
    int v;
    v = ((int'(raw) <<< sh) + 2) >>> 2;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  // Start pulses are counted here so no bench task races the one-cycle pulse
  always @(posedge mclk) begin
    if (!srst && conv_start === 1'b1) begin
      n_start++;
      fr_seen = filter_reset;
      sw_seen = swap_inputs;
    end
  end

  always @(posedge mclk) begin
    if (!srst && result_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("result_unexpected", 32'h1, 32'h0);
      else chk("result_word", result_word, exp_q.pop_front());
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int k;
    k = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk("pready", pready, 1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1, a, d, rd, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic e;
    apb(0, a, 32'h0, rd, e);
    chk("prdata", rd, exp);
    chk("pslverr", e, experr);
  endtask

  // mode 0 no result, 1 plain result, 2 halved difference against prev
  task automatic do_conv(input logic sw, input logic [2:0] g, input logic [1:0] bo,
                         input int mode, input logic [15:0] prev, output logic [15:0] code);
    logic [17:0] raw;
    int k, sh;
    k = 0;
    sh = (g == 3'h7) ? 2 : (g == 3'h6) ? 1 : 0;
    while (n_start == seen_starts && k < 50) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 50) chk("conv_start", 32'h0, 32'h1);
    seen_starts = n_start;
    chk("filter_reset", fr_seen, 1);
    chk("swap_inputs", sw_seen, sw);
    @(posedge mclk);
    chk("vin_pos_sel", vin_pos_sel, sw ? insel[3:0] : insel[7:4]);
    chk("vin_neg_sel", vin_neg_sel, sw ? insel[7:4] : insel[3:0]);
    chk("analog_gain", analog_gain, (g > 3'h5) ? 3'h5 : g);
    chk("digital_shift", digital_shift, sh);
    chk("burnout_sel", burnout_sel, bo);
    lfsr = lfsr_next(lfsr);
    // A small fixed code on the first x2 half lands exactly on a rounding step
    raw = (sh == 1 && !sw) ? 18'h00006 : {lfsr[1:0], lfsr};
    code = gained(raw, sh);
    if (mode == 1) last_exp = code;
    if (mode == 2) last_exp = 16'((int'($signed(prev)) - int'($signed(code))) >>> 1);
    if (mode != 0) exp_q.push_back(last_exp);
    conv_done <= 1;
    conv_raw <= raw;
    @(posedge mclk);
    conv_done <= 0;
  endtask

  task automatic oneshot(input logic [1:0] bo, input logic [2:0] g, input logic az,
                         input logic [1:0] bo_exp);
    logic [15:0] c1, c2;
    int s0, k;
    s0 = n_start;
    k = 0;
    wr(OFF_SETUP, {23'h0, 1'b1, 2'b00, az, g, bo});
    do_conv(0, g, bo_exp, az ? 0 : 1, 16'h0, c1);
    if (az) do_conv(1, g, bo_exp, 2, c1, c2);
    while (exp_q.size() != 0 && k < 20) begin
      @(posedge mclk);
      k++;
    end
    repeat (3) @(posedge mclk);
    chk("start_count", n_start - s0, az ? 2 : 1);
  endtask

  initial begin
    logic [15:0] c1, c2;
    repeat (6) @(posedge mclk);
    srst <= 0;
    @(posedge mclk);
    rdchk(OFF_SETUP, {23'h0, SETUP_RST}, 0);
    rdchk(OFF_INSEL, {24'h0, INSEL_RST}, 0);
    rdchk(8'h10, 32'h0, 1);
    insel = 8'h12;
    wr(OFF_INSEL, {24'h0, insel});
    for (int g = 0; g < 8; g++) begin
      oneshot(g[1:0], g[2:0], (g == 3 || g == 6), g[1:0]);
    end
    // Gain change without a start must wait for the next conversion
    wr(OFF_SETUP, 32'h0);
    chk("analog_gain_held", analog_gain, 3'h5);
    insel = TEMP_PAIR;
    wr(OFF_INSEL, {24'h0, insel});
    chk("diode_bias_en", diode_bias_en, 1);
    oneshot(2'h3, 3'h1, 0, BURN_OFF);
    rdchk(OFF_SETUP, 32'h7, 0);
    insel = 8'h12;
    wr(OFF_INSEL, {24'h0, insel});
    scan_temp_active <= 1;
    repeat (2) @(posedge mclk);
    chk("burnout_scan", burnout_sel, BURN_OFF);
    chk("diode_bias_scan", diode_bias_en, 1);
    scan_temp_active <= 0;
    repeat (2) @(posedge mclk);
    chk("burnout_back", burnout_sel, 2'h3);
    chk("diode_bias_off", diode_bias_en, 0);
    seen_starts = n_start;
    wr(OFF_SETUP, {23'h0, 1'b0, KIND_CONT, 1'b1, 3'h2, 2'h1});
    do_conv(0, 3'h2, 2'h1, 0, 16'h0, c1);
    do_conv(1, 3'h2, 2'h1, 2, c1, c2);
    do_conv(0, 3'h2, 2'h1, 0, 16'h0, c1);
    wr(OFF_SETUP, {23'h0, 1'b0, 2'b00, 1'b1, 3'h2, 2'h1});
    do_conv(1, 3'h2, 2'h1, 2, c1, c2);
    repeat (10) @(posedge mclk);
    chk("cont_stop", n_start - seen_starts, 0);
    chk("queue_empty", exp_q.size(), 0);
    // Idle, no temp pick, offset cancel still latched from the last restart
    rdchk(OFF_STATUS, 32'h8, 0);
    rdchk(OFF_RESULT, {16'h0, last_exp}, 0);
    complete_run();
  end
endmodule // adc_front_end_control_tb_top
